//--- pci_target_end.sv
// Purpose: Bridge end on the secondary PCI bus (target side, upstream)
// Assumes: Window inputs hold the downstream prefetchable range
// Notes:   Posted memory writes, delayed I/O writes, retry for the rest
//
// Functional notes
// - Target takes listed commands; master never last four
// - Reserved codes never issued, never claimed
// - Interrupt acknowledge never issued nor claimed
// - Special cycles are never claimed
// - Type 0 configuration never claimed
// - Write-and-invalidate posted as plain write
// - Misaligned start disconnects after first transfer
// - Dual address: low half, then command plus high
// - Dual address claimed only for memory commands
// - Dual address outside window goes upstream only
// - Positive decode, medium device select
// - Transfer only when both readies asserted
// - Final phase: frame high with readies, or stop
// - Posted write: space check, select and ready together
// - Posted data taken every clock, no waits
// - Disconnect on page boundary or full buffer
// - I/O writes delayed, one doubleword each
// - First I/O write: select, retry, capture request
// - Queue only unmatched requests with free slot
// - Repeat at done head completes with ready
// - Repeat during delivery keeps getting retry
// - Back-to-back writes recognised, never merged
`default_nettype none
module pci_target_end
  import pci_bridge_pkg::*;
(
  input  wire logic        ref_clk_i,    // Bus clock
  input  wire logic        reset_i,      // Sync reset
  pci_link_if.target       bus,          // PCI bus
  input  wire logic [11:0] win_base_i,   // Window base, addr 31:20
  input  wire logic [11:0] win_lim_i,    // Window limit, addr 31:20
  input  wire logic        up_ready_i,   // Upstream accepts word
  output logic             up_valid_o,   // Upstream word valid
  output logic             up_dly_o,     // Word is a delayed write
  output logic [3:0]       up_cmd_o,     // Word command
  output logic [31:0]      up_addr_o,    // Word address
  output logic [31:0]      up_data_o,    // Word data
  output logic [3:0]       up_be_o,      // Byte enables, high active
  input  wire logic        mst_req_i,    // Downstream command request
  input  wire logic [3:0]  mst_cmd_i,    // Requested command
  output logic             mst_ok_o,     // Command may be issued
  output logic             mst_bad_o     // Command refused
);
  typedef enum logic [2:0] {S_IDLE, S_DAC, S_DEC, S_POST, S_DWR, S_DONE} tgt_state_t;

  // ==========================================================
  // Bus observation
  tgt_state_t  st_r;
  logic        frame_q_r, last_q_r, devsel_r, trdy_r, stop_r;
  logic [3:0]  cmd_r;
  logic [31:0] addr_r;
  logic        dac_r, hi_nz_r, apar_r, dpar_pend_r;

  assign bus.devsel_n = devsel_r;
  assign bus.trdy_n   = trdy_r;
  assign bus.stop_n   = stop_r;

  wire xfer    = !bus.irdy_n && !bus.trdy_n;
  wire fin     = !bus.irdy_n && ((bus.frame_n && !bus.trdy_n) || !bus.stop_n);
  wire addr_ph = !bus.frame_n && (frame_q_r || last_q_r);

  // ==========================================================
  // Decode
  wire in_win  = !hi_nz_r && addr_r[31:WIN_LSB] >= win_base_i
                 && addr_r[31:WIN_LSB] <= win_lim_i;
  wire is_cfg  = cmd_r == CMD_CFGRD || cmd_r == CMD_CFGWR;
  wire cmd_ok  = dac_r ? is_mem(cmd_r) : target_ok(cmd_r);
  wire claim   = cmd_ok && !(is_mem(cmd_r) && in_win)
                 && !(is_cfg && addr_r[1:0] != CFG_TYPE1);
  wire is_post = cmd_r == CMD_MWR || cmd_r == CMD_MWI;
  wire is_iow  = cmd_r == CMD_IOWR;

  // ==========================================================
  // Posted write buffer
  logic [31:0]         pw_addr [PW_DEPTH];
  logic [31:0]         pw_data [PW_DEPTH];
  logic [3:0]          pw_be   [PW_DEPTH];
  logic [3:0]          pw_cmd  [PW_DEPTH];
  logic [PW_IDX_W-1:0] pw_wr_r, pw_rd_r;
  logic [3:0]          pw_cnt_r;

  wire        load   = !up_valid_o || up_ready_i;
  wire        push   = st_r == S_POST && xfer;
  wire        pw_pop = load && pw_cnt_r != 4'h0;
  wire [3:0]  space  = PW_DEPTH_C - pw_cnt_r;
  wire [31:0] nxt_a  = addr_r + 32'h4;
  wire        pg_end_now = &addr_r[PAGE_MSB:PAGE_LSB];
  wire        pg_end_nxt = &nxt_a[PAGE_MSB:PAGE_LSB];
  wire        first_stop = addr_r[1:0] != 2'h0 || pg_end_now || space == 4'h1;
  wire        next_stop  = pg_end_nxt || space == 4'h2;

  // ==========================================================
  // Delayed write queue, two slots
  logic        dq_v     [2];
  logic [1:0]  dq_st    [2];   // 0 queued, 1 sending, 2 delivered
  logic [31:0] dq_addr  [2];
  logic [31:0] dq_data  [2];
  logic [3:0]  dq_cmd   [2];
  logic [3:0]  dq_be    [2];
  logic        dq_apar  [2];
  logic        dq_dpar  [2];
  logic        dq_hd_r;

  wire        tail   = dq_v[dq_hd_r] ? !dq_hd_r : dq_hd_r;
  wire        dq_full = dq_v[0] && dq_v[1];
  wire [1:0]  hit;
  assign hit[0] = dq_v[0] && dq_addr[0] == addr_r && dq_cmd[0] == cmd_r;
  assign hit[1] = dq_v[1] && dq_addr[1] == addr_r && dq_cmd[1] == cmd_r;
  wire        be_eq   = dq_be[dq_hd_r] == ~bus.cbe_n;
  wire        hd_done = hit[dq_hd_r] && be_eq && dq_st[dq_hd_r] == 2'h2;
  wire        dq_go   = load && pw_cnt_r == 4'h0 && dq_v[dq_hd_r] && dq_st[dq_hd_r] == 2'h0;
  wire        dwr_ph  = st_r == S_DWR && !bus.irdy_n;
  wire        dq_push = dwr_ph && !hd_done && hit == 2'h0 && !dq_full;
  wire        dq_pop  = dwr_ph && hd_done;
  wire        dly_acc = up_valid_o && up_ready_i && up_dly_o;

  // ==========================================================
  // Target state machine
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_r <= S_IDLE;
      frame_q_r <= 1'b1;
      last_q_r <= 1'b0;
      devsel_r <= 1'b1;
      trdy_r <= 1'b1;
      stop_r <= 1'b1;
      cmd_r <= 4'h0;
      addr_r <= 32'h0;
      dac_r <= 1'b0;
      hi_nz_r <= 1'b0;
      apar_r <= 1'b0;
    end
    else
    begin
      frame_q_r <= bus.frame_n;
      last_q_r <= fin;
      case (st_r)
        S_IDLE:
          if (addr_ph)
          begin
            cmd_r <= bus.cbe_n;
            addr_r <= bus.ad;
            dac_r <= 1'b0;
            hi_nz_r <= 1'b0;
            st_r <= bus.cbe_n == CMD_DAC ? S_DAC : S_DEC;
          end
        S_DAC:
        begin
          cmd_r <= bus.cbe_n;
          hi_nz_r <= |bus.ad;
          dac_r <= 1'b1;
          st_r <= S_DEC;
        end
        S_DEC:
        begin
          apar_r <= bus.par;
          if (!claim)
            st_r <= S_IDLE;
          else
          begin
            devsel_r <= 1'b0;
            if (is_post && space != 4'h0)
            begin
              trdy_r <= 1'b0;
              stop_r <= !first_stop;
              st_r <= S_POST;
            end
            else if (is_iow)
              st_r <= S_DWR;
            else
            begin
              stop_r <= 1'b0;
              st_r <= S_DONE;
            end
          end
        end
        S_POST:
          if (fin)
          begin
            devsel_r <= 1'b1;
            trdy_r <= 1'b1;
            stop_r <= 1'b1;
            st_r <= S_IDLE;
          end
          else if (xfer)
          begin
            addr_r <= nxt_a;
            if (next_stop)
              stop_r <= 1'b0;
          end
        S_DWR:
          if (!bus.irdy_n)
          begin
            stop_r <= 1'b0;
            trdy_r <= !hd_done;
            st_r <= S_DONE;
          end
        default:
          if (fin)
          begin
            devsel_r <= 1'b1;
            trdy_r <= 1'b1;
            stop_r <= 1'b1;
            st_r <= S_IDLE;
          end
      endcase
    end
  end

  // ==========================================================
  // Buffers and upstream stage
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      pw_wr_r <= '0;
      pw_rd_r <= '0;
      pw_cnt_r <= 4'h0;
      up_valid_o <= 1'b0;
      up_dly_o <= 1'b0;
      up_cmd_o <= 4'h0;
      up_addr_o <= 32'h0;
      up_data_o <= 32'h0;
      up_be_o <= 4'h0;
      dq_hd_r <= 1'b0;
      dq_v[0] <= 1'b0;
      dq_v[1] <= 1'b0;
      dpar_pend_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        pw_addr[pw_wr_r] <= addr_r;
        pw_data[pw_wr_r] <= bus.ad;
        pw_be[pw_wr_r] <= ~bus.cbe_n;
        pw_cmd[pw_wr_r] <= CMD_MWR;
        pw_wr_r <= pw_wr_r + 1'b1;
      end
      pw_cnt_r <= pw_cnt_r + {3'h0, push} - {3'h0, pw_pop};
      if (pw_pop)
      begin
        up_valid_o <= 1'b1;
        up_dly_o <= 1'b0;
        up_cmd_o <= pw_cmd[pw_rd_r];
        up_addr_o <= pw_addr[pw_rd_r];
        up_data_o <= pw_data[pw_rd_r];
        up_be_o <= pw_be[pw_rd_r];
        pw_rd_r <= pw_rd_r + 1'b1;
      end
      else if (dq_go)
      begin
        up_valid_o <= 1'b1;
        up_dly_o <= 1'b1;
        up_cmd_o <= dq_cmd[dq_hd_r];
        up_addr_o <= dq_addr[dq_hd_r];
        up_data_o <= dq_data[dq_hd_r];
        up_be_o <= dq_be[dq_hd_r];
        dq_st[dq_hd_r] <= 2'h1;
      end
      else if (load)
        up_valid_o <= 1'b0;
      if (dly_acc)
        dq_st[dq_hd_r] <= 2'h2;
      dpar_pend_r <= dq_push;
      if (dpar_pend_r)
        dq_dpar[dq_v[!dq_hd_r] ? !dq_hd_r : dq_hd_r] <= bus.par;
      if (dq_push)
      begin
        dq_v[tail] <= 1'b1;
        dq_st[tail] <= 2'h0;
        dq_addr[tail] <= addr_r;
        dq_cmd[tail] <= cmd_r;
        dq_be[tail] <= ~bus.cbe_n;
        dq_data[tail] <= bus.ad;
        dq_apar[tail] <= apar_r;
      end
      if (dq_pop)
      begin
        dq_v[dq_hd_r] <= 1'b0;
        dq_hd_r <= !dq_hd_r;
      end
    end
  end

  // ==========================================================
  // Downstream command filter
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      mst_ok_o <= 1'b0;
      mst_bad_o <= 1'b0;
    end
    else
    begin
      mst_ok_o <= mst_req_i && master_ok(mst_cmd_i);
      mst_bad_o <= mst_req_i && !master_ok(mst_cmd_i);
    end
  end
endmodule
`default_nettype wire

//--- pci_bridge_pkg.sv
// Purpose: Shared constants for the PCI-side bridge ends
// Assumes: 32-bit PCI bus, one clock
// Notes:   Command codes, queue sizes, bus timing
`default_nettype none
package pci_bridge_pkg;
  // ==========================================================
  // Bus commands
  localparam logic [3:0] CMD_INTA  = 4'h0;
  localparam logic [3:0] CMD_SPEC  = 4'h1;
  localparam logic [3:0] CMD_IORD  = 4'h2;
  localparam logic [3:0] CMD_IOWR  = 4'h3;
  localparam logic [3:0] CMD_RSV4  = 4'h4;
  localparam logic [3:0] CMD_RSV5  = 4'h5;
  localparam logic [3:0] CMD_MRD   = 4'h6;
  localparam logic [3:0] CMD_MWR   = 4'h7;
  localparam logic [3:0] CMD_RSV8  = 4'h8;
  localparam logic [3:0] CMD_RSV9  = 4'h9;
  localparam logic [3:0] CMD_CFGRD = 4'ha;
  localparam logic [3:0] CMD_CFGWR = 4'hb;
  localparam logic [3:0] CMD_MRM   = 4'hc;
  localparam logic [3:0] CMD_DAC   = 4'hd;
  localparam logic [3:0] CMD_MRL   = 4'he;
  localparam logic [3:0] CMD_MWI   = 4'hf;
  // ==========================================================
  // Address fields and sizes
  localparam logic [1:0] CFG_TYPE1   = 2'h1;
  localparam int         PAGE_LSB    = 2;
  localparam int         PAGE_MSB    = 11;
  localparam int         WIN_LSB     = 20;
  localparam int         PW_DEPTH    = 8;
  localparam int         PW_IDX_W    = 3;
  localparam logic [3:0] PW_DEPTH_C  = 4'h8;
  localparam logic [7:0] MABORT_CLKS = 8'h05;
  // ==========================================================
  // Host status codes
  localparam logic [1:0] ST_OK    = 2'h0;
  localparam logic [1:0] ST_RETRY = 2'h1;
  localparam logic [1:0] ST_DISC  = 2'h2;
  localparam logic [1:0] ST_ABORT = 2'h3;

  function automatic logic is_mem(input logic [3:0] c);
    return c == CMD_MRD || c == CMD_MWR || c == CMD_MRM || c == CMD_MRL || c == CMD_MWI;
  endfunction

  function automatic logic rsv_cmd(input logic [3:0] c);
    return c == CMD_RSV4 || c == CMD_RSV5 || c == CMD_RSV8 || c == CMD_RSV9;
  endfunction

  function automatic logic master_ok(input logic [3:0] c);
    return !rsv_cmd(c) && c != CMD_INTA && c < CMD_MRM;
  endfunction

  function automatic logic target_ok(input logic [3:0] c);
    return !rsv_cmd(c) && c != CMD_INTA && c != CMD_SPEC && c != CMD_DAC;
  endfunction
endpackage
`default_nettype wire

//--- pci_link_if.sv
// Purpose: PCI bus wires between initiator and bridge target
// Assumes: Target never drives AD (reads end in retry)
// Notes:   Active-low bus signals carry _n
`default_nettype none
interface pci_link_if;
  logic        frame_n;
  logic        irdy_n;
  logic        trdy_n;
  logic        stop_n;
  logic        devsel_n;
  logic        par;
  logic [31:0] ad;
  logic [3:0]  cbe_n;

  modport initiator (
    output frame_n, irdy_n, ad, cbe_n, par,
    input  trdy_n, stop_n, devsel_n
  );
  modport target (
    input  frame_n, irdy_n, ad, cbe_n, par,
    output trdy_n, stop_n, devsel_n
  );
endinterface
`default_nettype wire

//--- pci_init_end.sv
// Purpose: PCI initiator end that drives the bridge target
// Assumes: Writes only; burst data counts up from data_i
// Notes:   Dual address used when addr_hi_i is nonzero
`default_nettype none
module pci_init_end
  import pci_bridge_pkg::*;
(
  input  wire logic        ref_clk_i,   // Bus clock
  input  wire logic        reset_i,     // Sync reset
  pci_link_if.initiator    bus,         // PCI bus
  input  wire logic        req_i,       // Start transaction
  input  wire logic [3:0]  cmd_i,       // Bus command
  input  wire logic [31:0] addr_i,      // Address low half
  input  wire logic [31:0] addr_hi_i,   // Address high half
  input  wire logic [31:0] data_i,      // First data word
  input  wire logic [3:0]  be_i,        // Byte enables, high active
  input  wire logic [3:0]  len_i,       // Words, at least one
  output logic             busy_o,      // Transaction running
  output logic             done_o,      // End pulse
  output logic [1:0]       stat_o,      // End status
  output logic [3:0]       cnt_o        // Words transferred
);
  typedef enum logic [2:0] {H_IDLE, H_ADR, H_ADR2, H_DATA, H_ABORT} init_state_t;

  init_state_t st_r;
  logic        frame_r, irdy_r, par_r;
  logic [31:0] ad_r, hi_r;
  logic [3:0]  cbe_r, cmd_r, be_r, rem_r;
  logic [7:0]  tmo_r;

  assign bus.frame_n = frame_r;
  assign bus.irdy_n  = irdy_r;
  assign bus.ad      = ad_r;
  assign bus.cbe_n   = cbe_r;
  assign bus.par     = par_r;

  // ==========================================================
  // Phase decode
  wire xfer  = !irdy_r && !bus.trdy_n;
  wire fin   = !irdy_r && ((frame_r && !bus.trdy_n) || !bus.stop_n);
  wire dac   = addr_hi_i != 32'h0;
  wire go    = req_i;                                        // Any code, so the target is probed

  // ==========================================================
  // Initiator state machine
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_r <= H_IDLE;
      frame_r <= 1'b1;
      irdy_r <= 1'b1;
      par_r <= 1'b0;
      ad_r <= 32'h0;
      hi_r <= 32'h0;
      cbe_r <= 4'h0;
      cmd_r <= 4'h0;
      be_r <= 4'h0;
      rem_r <= 4'h0;
      tmo_r <= 8'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      stat_o <= ST_OK;
      cnt_o <= 4'h0;
    end
    else
    begin
      par_r <= ^{ad_r, cbe_r};
      done_o <= 1'b0;
      case (st_r)
        H_IDLE:
          if (go && len_i != 4'h0)
          begin
            frame_r <= 1'b0;
            ad_r <= addr_i;
            cbe_r <= dac ? CMD_DAC : cmd_i;
            hi_r <= addr_hi_i;
            cmd_r <= cmd_i;
            be_r <= be_i;
            rem_r <= len_i;
            cnt_o <= 4'h0;
            tmo_r <= 8'h0;
            busy_o <= 1'b1;
            st_r <= dac ? H_ADR2 : H_ADR;
          end
        H_ADR2:
        begin
          ad_r <= hi_r;
          cbe_r <= cmd_r;
          st_r <= H_ADR;
        end
        H_ADR:
        begin
          irdy_r <= 1'b0;
          ad_r <= data_i;
          cbe_r <= ~be_r;
          frame_r <= rem_r == 4'h1;
          st_r <= H_DATA;
        end
        H_DATA:
        begin
          tmo_r <= tmo_r + 8'h1;
          if (fin)
          begin
            frame_r <= 1'b1;
            irdy_r <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            cnt_o <= cnt_o + {3'h0, xfer};
            stat_o <= bus.stop_n ? ST_OK : (cnt_o == 4'h0 && !xfer) ? ST_RETRY : ST_DISC;
            st_r <= H_IDLE;
          end
          else if (xfer)
          begin
            ad_r <= ad_r + 32'h1;
            cnt_o <= cnt_o + 4'h1;
            rem_r <= rem_r - 4'h1;
            frame_r <= rem_r == 4'h2;
          end
          else if (bus.devsel_n && tmo_r == MABORT_CLKS)
          begin
            frame_r <= 1'b1;
            st_r <= H_ABORT;
          end
        end
        default:
        begin
          irdy_r <= 1'b1;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          stat_o <= ST_ABORT;
          st_r <= H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- pci_side_bridge_monitor.sv
// Purpose: Bus-level checks between initiator and bridge target ends
// Assumes: One clock, synchronous active-high reset
// Notes:   Takes the link signals as plain inputs
`default_nettype none
module pci_side_bridge_monitor
  import pci_bridge_pkg::*;
(
  input wire logic        ref_clk_i,  // Bus clock
  input wire logic        reset_i,    // Sync reset
  input wire logic        frame_n,    // Frame
  input wire logic        irdy_n,     // Initiator ready
  input wire logic        trdy_n,     // Target ready
  input wire logic        stop_n,     // Stop
  input wire logic        devsel_n,   // Device select
  input wire logic        par,        // Parity
  input wire logic [31:0] ad,         // Address and data
  input wire logic [3:0]  cbe_n       // Command and byte enables
);
  // ==========================================================
  // Phase tracking
  logic       frame_r;
  logic       fin_r;
  logic       sec_r;
  logic       mis_r;
  logic [3:0] cmd_r;
  wire        fin   = !irdy_n && (!stop_n || (frame_n && !trdy_n));
  wire        start = !frame_n && (frame_r || fin_r);
  wire        xfer  = !irdy_n && !trdy_n;
  wire        skip  = cbe_n inside {CMD_INTA, CMD_SPEC, CMD_RSV4, CMD_RSV5, CMD_RSV8, CMD_RSV9}
                      || (cbe_n inside {CMD_CFGRD, CMD_CFGWR} && ad[1:0] == 2'h0);
  wire        memc  = cbe_n inside {CMD_MRD, CMD_MWR, CMD_MRM, CMD_MRL, CMD_MWI};
  wire        wr_r  = cmd_r == CMD_MWR || cmd_r == CMD_MWI;

  always_ff @(posedge ref_clk_i)
  begin
    frame_r <= reset_i ? 1'b1 : frame_n;
    fin_r   <= reset_i ? 1'b0 : fin;
    sec_r   <= !reset_i && start && cbe_n == CMD_DAC;
    mis_r   <= reset_i ? 1'b0 : (start ? |ad[1:0] : mis_r);
    cmd_r   <= reset_i ? 4'h0 : ((start || sec_r) ? cbe_n : cmd_r);
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // ==========================================================
  // Checks
  a_trdy_with_sel:  assert property (!trdy_n || !stop_n |-> !devsel_n)
    else $error("target ready or stop without device select");
  a_medium_devsel:  assert property (start |=> devsel_n)
    else $error("device select faster than medium");
  a_skip_cmd:       assert property (start && skip |=> devsel_n [*4])
    else $error("ignored command was claimed");
  a_dac_nonmem:     assert property (start && cbe_n == CMD_DAC ##1 !memc |=> devsel_n [*3])
    else $error("dual address with non-memory command claimed");
  a_post_at_once:   assert property ($fell(devsel_n) && wr_r |-> !trdy_n || !stop_n)
    else $error("posted write claim without ready or retry");
  a_no_wait_state:  assert property (xfer && !frame_n && stop_n |=> !trdy_n)
    else $error("wait state inserted in posted burst");
  a_release_fin:    assert property (fin |=> devsel_n && trdy_n && stop_n)
    else $error("target outputs held after final phase");
  a_misalign_disc:  assert property (xfer && mis_r && wr_r |-> !stop_n)
    else $error("misaligned burst not disconnected");
  a_io_single:      assert property (xfer && cmd_r == CMD_IOWR |-> !stop_n)
    else $error("delayed write not single doubleword");
endmodule
`default_nettype wire

//--- pci_side_bridge_transaction_unit_tb.sv
// Purpose: Self-checking bench for initiator and bridge target ends
// Assumes: Window at addr 31:20 == 001, upstream side driven by bench
// Notes:   Bench drives inputs on the falling edge
`default_nettype none
module pci_side_bridge_transaction_unit_tb
  import pci_bridge_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i;
  logic        reset_i;
  logic        req_i;
  logic [3:0]  cmd_i;
  logic [31:0] addr_i;
  logic [31:0] addr_hi_i;
  logic [31:0] data_i;
  logic [3:0]  len_i;
  logic        up_ready_i;
  logic        mst_req_i;
  logic [3:0]  mst_cmd_i;
  logic [3:0]  be_i;
  wire         up_valid_o, up_dly_o, busy_o, done_o, mst_ok_o, mst_bad_o;
  wire  [3:0]  up_cmd_o, up_be_o, cnt_o;
  wire  [31:0] up_addr_o, up_data_o;
  wire  [1:0]  stat_o;
  int          errors, n_compared, cyc;
  logic [31:0] aq[$], dq[$];
  logic        lq[$];
  logic [7:0]  cq[$];
  logic [3:0]  skip_c[8] = '{CMD_INTA, CMD_SPEC, CMD_RSV4, CMD_RSV5, CMD_RSV8, CMD_RSV9,
                             CMD_CFGRD, CMD_MWR};

  pci_link_if link ();
  pci_target_end pci_target_end_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(link),
    .win_base_i(12'h001), .win_lim_i(12'h001), .up_ready_i(up_ready_i),
    .up_valid_o(up_valid_o), .up_dly_o(up_dly_o), .up_cmd_o(up_cmd_o), .up_addr_o(up_addr_o),
    .up_data_o(up_data_o), .up_be_o(up_be_o), .mst_req_i(mst_req_i), .mst_cmd_i(mst_cmd_i),
    .mst_ok_o(mst_ok_o), .mst_bad_o(mst_bad_o));
  pci_init_end pci_init_end_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(link),
    .req_i(req_i), .cmd_i(cmd_i), .addr_i(addr_i), .addr_hi_i(addr_hi_i), .data_i(data_i),
    .be_i(be_i), .len_i(len_i), .busy_o(busy_o), .done_o(done_o), .stat_o(stat_o),
    .cnt_o(cnt_o));
  pci_side_bridge_monitor pci_side_bridge_monitor_inst (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .frame_n(link.frame_n), .irdy_n(link.irdy_n), .trdy_n(link.trdy_n),
    .stop_n(link.stop_n), .devsel_n(link.devsel_n), .par(link.par), .ad(link.ad),
    .cbe_n(link.cbe_n));

  // ==========================================================
  // Clock, timeout and upstream capture
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (!reset_i && up_valid_o === 1'b1 && up_ready_i)
    begin
      aq.push_back(up_addr_o);
      dq.push_back(up_data_o);
      lq.push_back(up_dly_o);
      cq.push_back({up_cmd_o, up_be_o});
    end
    if (cyc == 20000)
    begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run(input logic [3:0] c, input logic [31:0] a, input logic [31:0] h,
                     input logic [31:0] d, input logic [3:0] n, input logic [1:0] es,
                     input logic [3:0] ec);
    int k;
    @(negedge ref_clk_i);
    cmd_i = c;
    addr_i = a;
    addr_hi_i = h;
    data_i = d;
    len_i = n;
    req_i = 1'b1;
    k = 0;
    do
    begin
      @(negedge ref_clk_i);
      if (busy_o === 1'b1)
        req_i = 1'b0;
      k++;
    end
    while (done_o !== 1'b1 && k < 80);
    req_i = 1'b0;
    check(done_o, 1'b1);
    check(stat_o, es);
    check(cnt_o, ec);
    check(busy_o, 1'b0);
  endtask

  task automatic up_chk(input logic [31:0] a, input logic [31:0] d, input logic dly);
    int k;
    for (k = 0; k < 60 && aq.size() == 0; k++)
      @(negedge ref_clk_i);
    if (aq.size() == 0)
      check(32'h0, 32'h1);
    else
    begin
      check(aq.pop_front() >> 2, a >> 2);
      check(dq.pop_front(), d);
      check(lq.pop_front(), dly);
      check(cq.pop_front(), {dly ? CMD_IOWR : CMD_MWR, be_i});
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    reset_i = 1'b1;
    {req_i, mst_req_i} = 2'b00;
    {cmd_i, mst_cmd_i, len_i} = 12'h0;
    {addr_i, addr_hi_i, data_i} = 96'h0;
    up_ready_i = 1'b1;
    be_i = 4'hf;
    repeat (3) @(negedge ref_clk_i);
    reset_i = 1'b0;
    // Command filter toward the bus
    for (int i = 0; i < 16; i++)
    begin
      @(negedge ref_clk_i);
      mst_req_i = 1'b1;
      mst_cmd_i = i[3:0];
      @(negedge ref_clk_i);
      mst_req_i = 1'b0;
      check(mst_ok_o, i[3:0] inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb});
      check(mst_bad_o, !(i[3:0] inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'ha, 4'hb}));
    end
    // Ignored commands end in master abort
    for (int i = 0; i < 8; i++)
      run(skip_c[i], (i == 7) ? 32'h0010_0000 : 32'h0020_0000, 0, 1, 1, ST_ABORT, 0);
    run(CMD_DAC, 32'h0020_0000, 1, 1, 1, ST_ABORT, 0);
    run(CMD_IOWR, 32'h0020_0000, 1, 1, 1, ST_ABORT, 0);
    // Posted bursts
    run(CMD_MWR, 32'h0020_0100, 0, 32'h1000, 3, ST_OK, 3);
    for (int i = 0; i < 3; i++)
      up_chk(32'h0020_0100 + 4 * i, 32'h1000 + i, 1'b0);
    run(CMD_MWI, 32'h0020_0200, 0, 32'h2000, 2, ST_OK, 2);
    up_chk(32'h0020_0200, 32'h2000, 1'b0);
    up_chk(32'h0020_0204, 32'h2001, 1'b0);
    run(CMD_MWR, 32'h0020_0001, 0, 32'h3000, 3, ST_DISC, 1);
    up_chk(32'h0020_0000, 32'h3000, 1'b0);
    run(CMD_MWR, 32'h0020_0ff8, 0, 32'h4000, 4, ST_DISC, 2);
    up_chk(32'h0020_0ff8, 32'h4000, 1'b0);
    up_chk(32'h0020_0ffc, 32'h4001, 1'b0);
    run(CMD_MWR, 32'h0010_0040, 1, 32'h5000, 1, ST_OK, 1);
    up_chk(32'h0010_0040, 32'h5000, 1'b0);
    // Buffer fill, then retry of the following write
    up_ready_i = 1'b0;
    // Buffer slots plus the output stage
    run(CMD_MWR, 32'h0020_0400, 0, 32'h6000, 12, ST_DISC, PW_DEPTH + 1);
    run(CMD_MWR, 32'h0020_0500, 0, 32'h7000, 1, ST_RETRY, 0);
    up_ready_i = 1'b1;
    for (int i = 0; i < PW_DEPTH + 1; i++)
      up_chk(32'h0020_0400 + 4 * i, 32'h6000 + i, 1'b0);
    // Delayed I/O write
    up_ready_i = 1'b0;
    run(CMD_IOWR, 32'h0000_1000, 0, 32'h55, 1, ST_RETRY, 0);
    run(CMD_IOWR, 32'h0000_1000, 0, 32'h55, 1, ST_RETRY, 0);
    up_ready_i = 1'b1;
    up_chk(32'h0000_1000, 32'h55, 1'b1);
    repeat (4) @(negedge ref_clk_i);
    check(aq.size(), 0);
    be_i = 4'h1;
    run(CMD_IOWR, 32'h0000_1000, 0, 32'h55, 1, ST_RETRY, 0);
    be_i = 4'hf;
    run(CMD_IOWR, 32'h0000_1000, 0, 32'h55, 1, ST_DISC, 1);
    print_verdict();
  end
endmodule
`default_nettype wire
